//--- src/plpc_msg_gen.sv
// pme message generator with periodic resend while the pme input is low
`timescale 1ns/10ps
module plpc_msg_gen (
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic        pme_n_i,
   input  wire logic [7:0]  sec_bus_i,
   input  wire logic        msg_ready_i,
   output logic             msg_valid_o,
   output logic [15:0]      msg_req_id_o,
   output logic [7:0]       msg_tag_o,
   output logic [7:0]       msg_code_o
);
   typedef struct packed {
      logic                                pme_prev;
      logic                                pend;
      logic [plpc_pkg::PME_CNT_W-1:0]      cnt;
      logic                                valid;
      logic [15:0]                         req_id;
   } plpc_mg_t;
   plpc_mg_t st;
   plpc_mg_t next_st;

   always_comb begin
      next_st = st;
      next_st.pme_prev = pme_n_i;
      if (st.valid && msg_ready_i) begin
         next_st.valid = 1'b0;
      end
      if (pme_n_i) begin
         next_st.pend = 1'b0; // RULE5
         next_st.cnt  = '0;
      end else if (st.pme_prev) begin
         next_st.pend = 1'b1; // RULE2
         next_st.cnt  = '0;
      end else if (st.cnt == plpc_pkg::PME_CNT_W'(plpc_pkg::PME_RESEND_CYC - 1)) begin
         next_st.pend = 1'b1; // RULE6
         next_st.cnt  = '0;
      end else begin
         next_st.cnt = st.cnt + 1'b1;
      end
      if (st.pend && !st.valid) begin
         next_st.valid  = 1'b1;
         next_st.pend   = 1'b0;
         next_st.cnt    = '0; // RULE6
         next_st.req_id = {sec_bus_i, plpc_pkg::REQ_DEVICE, plpc_pkg::REQ_FUNCTION}; // RULE3
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st          <= '0;
         st.pme_prev <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign msg_valid_o  = st.valid;
   assign msg_req_id_o = st.req_id;
   assign msg_tag_o    = plpc_pkg::PME_TAG; // RULE4
   assign msg_code_o   = plpc_pkg::MSG_CODE_PME;
endmodule

//--- src/plpc_pkg.sv
// package of constants and types for the pci lock and pme conversion block
// Summary of operation
// RULE1 - sideband interrupt edges become intx assert/deassert messages
// RULE2 - falling pme input sends pme message upstream
// RULE3 - requester id: secondary bus, device 0, function 0
// RULE4 - pme message tag is always zero
// RULE5 - resend pme while input low, stop when high
// RULE6 - fixed resend interval, restarted on each send
// RULE7 - lock pin driven only when lock enable set
// RULE8 - locked sequences only downstream, never upstream
// RULE9 - locked read forwarded as read, locked completion
// RULE10 - unlocked bridge requests bus for locked read
// RULE11 - grant with lock high: assert lock after address
// RULE12 - owner keeps lock low except address phases
// RULE13 - grant with lock low: drop request, wait idle
// RULE14 - after read data, lock and block others
// RULE15 - writes while locked issued as locked writes
// RULE16 - release lock after unlock and transactions done
// RULE17 - normal read while locked gets unsupported request
// RULE18 - root complex blocks normal reads during lock
// RULE19 - upstream sends unlock after every locked sequence
package plpc_pkg;
   localparam int unsigned CLK_HZ          = 50000000;
   localparam int unsigned PME_RESEND_US   = 1000;
   localparam int unsigned PME_RESEND_CYC  = (CLK_HZ / 1000000) * PME_RESEND_US;
   localparam int unsigned PME_CNT_W       = 16;
   localparam logic [7:0]  MSG_CODE_PME    = 8'h18;
   localparam logic [7:0]  MSG_CODE_ASSERT = 8'h20;
   localparam logic [7:0]  MSG_CODE_DEASRT = 8'h24;
   localparam logic [7:0]  PME_TAG         = 8'h00;
   localparam logic [4:0]  REQ_DEVICE      = 5'h00;
   localparam logic [2:0]  REQ_FUNCTION    = 3'h0;
   localparam logic [2:0]  CPL_STATUS_SC   = 3'h0;
   localparam logic [2:0]  CPL_STATUS_UR   = 3'h1;
   localparam int unsigned LOCK_EN_BIT     = 12;
   localparam logic [1:0]  CMD_NONE        = 2'h0;
   localparam logic [1:0]  CMD_READ        = 2'h1;
   localparam logic [1:0]  CMD_WRITE       = 2'h2;
   typedef enum logic [2:0] {
      PLPC_IDLE,
      PLPC_REQ,
      PLPC_BACKOFF,
      PLPC_ADDR,
      PLPC_WAIT_DATA,
      PLPC_LOCKED,
      PLPC_DRAIN
   } plpc_lock_st_t;
endpackage

//--- src/plpc_top.sv
// lock conversion and pme message top of the pci express to pci bridge
`timescale 1ns/10ps
module plpc_top (
   input  wire logic        core_clk_i,
   input  wire logic        reset_i,
   input  wire logic [31:0] gen_ctrl_i,
   input  wire logic [7:0]  sec_bus_i,
   input  wire logic        pme_n_i,
   input  wire logic        pme_msg_ready_i,
   output logic             pme_msg_valid_o,
   output logic [15:0]      pme_msg_req_id_o,
   output logic [7:0]       pme_msg_tag_o,
   output logic [7:0]       pme_msg_code_o,
   input  wire logic [3:0]  intx_n_i,
   input  wire logic        intx_msg_ready_i,
   output logic             intx_msg_valid_o,
   output logic [7:0]       intx_msg_code_o,
   input  wire logic        dn_valid_i,
   input  wire logic [1:0]  dn_cmd_i,
   input  wire logic        dn_locked_i,
   input  wire logic        dn_unlock_i,
   output logic             dn_ready_o,
   output logic             cpl_valid_o,
   output logic             cpl_locked_o,
   output logic [2:0]       cpl_status_o,
   output logic             pci_start_o,
   output logic [1:0]       pci_cmd_o,
   output logic             pci_lock_xfer_o,
   input  wire logic        pci_addr_phase_i,
   input  wire logic        pci_done_i,
   input  wire logic        pci_bus_idle_i,
   output logic             req_n_o,
   input  wire logic        gnt_n_i,
   input  wire logic        lock_n_i,
   output logic             lock_n_o,
   output logic             lock_n_oe_n_o
);
   typedef struct packed {
      plpc_pkg::plpc_lock_st_t  ls;
      logic [3:0]               intx_prev;
      logic [3:0]               intx_pend_a;
      logic [3:0]               intx_pend_d;
      logic                     intx_valid;
      logic [7:0]               intx_code;
      logic                     unlock_seen;
      logic                     busy;
      logic                     cpl_valid;
      logic                     cpl_locked;
      logic [2:0]               cpl_status;
      logic                     pci_start;
      logic [1:0]               pci_cmd;
      logic                     pci_lock_xfer;
      logic                     req_n;
      logic                     lock_drv;
      logic                     dn_ready;
   } plpc_top_t;
   plpc_top_t st;
   plpc_top_t next_st;
   logic      lock_en;
   logic      take;

   assign lock_en = gen_ctrl_i[plpc_pkg::LOCK_EN_BIT];
   assign take    = dn_valid_i && st.dn_ready;

   plpc_msg_gen u_msg_gen (
      .core_clk_i   (core_clk_i),
      .reset_i      (reset_i),
      .pme_n_i      (pme_n_i),
      .sec_bus_i    (sec_bus_i),
      .msg_ready_i  (pme_msg_ready_i),
      .msg_valid_o  (pme_msg_valid_o),
      .msg_req_id_o (pme_msg_req_id_o),
      .msg_tag_o    (pme_msg_tag_o),
      .msg_code_o   (pme_msg_code_o)
   );

   always_comb begin
      logic found;
      found   = 1'b0;
      next_st = st;
      next_st.cpl_valid = 1'b0;
      next_st.pci_start = 1'b0;
      next_st.dn_ready  = 1'b0;
      // intx: one message at a time, lowest line first; only the served flag is cleared
      if (st.intx_valid && intx_msg_ready_i) begin
         next_st.intx_valid = 1'b0;
      end else if (!st.intx_valid) begin
         for (int i = 0; i < 4; i++) begin
            if (!found && st.intx_pend_a[i]) begin
               found                  = 1'b1;
               next_st.intx_valid     = 1'b1;
               next_st.intx_code      = plpc_pkg::MSG_CODE_ASSERT | 8'(i); // RULE1
               next_st.intx_pend_a[i] = 1'b0;
            end else if (!found && st.intx_pend_d[i]) begin
               found                  = 1'b1;
               next_st.intx_valid     = 1'b1;
               next_st.intx_code      = plpc_pkg::MSG_CODE_DEASRT | 8'(i);
               next_st.intx_pend_d[i] = 1'b0;
            end
         end
      end
      // edges are recorded after the service step so a fresh edge is never lost
      next_st.intx_prev = intx_n_i;
      for (int i = 0; i < 4; i++) begin
         if (st.intx_prev[i] && !intx_n_i[i]) begin
            next_st.intx_pend_a[i] = 1'b1; // RULE1
         end
         if (!st.intx_prev[i] && intx_n_i[i]) begin
            next_st.intx_pend_d[i] = 1'b1; // RULE1
         end
      end
      // downstream request intake; one pci transfer outstanding at a time
      if (dn_unlock_i) begin
         next_st.unlock_seen = 1'b1;
      end
      if (pci_done_i) begin
         next_st.busy = 1'b0;
      end
      if (take) begin
         if (dn_cmd_i == plpc_pkg::CMD_READ && !dn_locked_i &&
             (st.ls == plpc_pkg::PLPC_LOCKED)) begin
            next_st.cpl_valid  = 1'b1; // RULE17
            next_st.cpl_locked = 1'b0;
            next_st.cpl_status = plpc_pkg::CPL_STATUS_UR;
         end else if (dn_cmd_i == plpc_pkg::CMD_READ && dn_locked_i && lock_en &&
                      (st.ls == plpc_pkg::PLPC_IDLE)) begin
            next_st.ls      = plpc_pkg::PLPC_REQ; // RULE10
            next_st.req_n   = 1'b0;
            next_st.pci_cmd = plpc_pkg::CMD_READ;
         end else if (dn_cmd_i != plpc_pkg::CMD_NONE) begin
            // locked state: writes join the sequence; unlocked: plain forward
            next_st.pci_start     = 1'b1;
            next_st.pci_cmd       = dn_cmd_i;
            next_st.pci_lock_xfer = (st.ls == plpc_pkg::PLPC_LOCKED); // RULE15 RULE9
            next_st.busy          = 1'b1;
         end
      end
      // lock ownership machine; upstream traffic never enters it
      case (st.ls) // RULE8
         plpc_pkg::PLPC_IDLE: begin
            next_st.lock_drv    = 1'b0;
            next_st.unlock_seen = 1'b0;
         end
         plpc_pkg::PLPC_REQ: begin
            if (!gnt_n_i && lock_n_i) begin
               next_st.ls            = plpc_pkg::PLPC_ADDR; // RULE11
               next_st.pci_start     = 1'b1;
               next_st.pci_lock_xfer = 1'b1;
               next_st.busy          = 1'b1;
            end else if (!gnt_n_i) begin
               next_st.ls    = plpc_pkg::PLPC_BACKOFF; // RULE13
               next_st.req_n = 1'b1;
            end
         end
         plpc_pkg::PLPC_BACKOFF: begin
            if (lock_n_i && pci_bus_idle_i) begin
               next_st.ls    = plpc_pkg::PLPC_REQ; // RULE13
               next_st.req_n = 1'b0;
            end
         end
         plpc_pkg::PLPC_ADDR: begin
            next_st.req_n = 1'b1;
            if (pci_addr_phase_i) begin
               next_st.ls       = plpc_pkg::PLPC_WAIT_DATA;
               next_st.lock_drv = 1'b1; // RULE11
            end
         end
         plpc_pkg::PLPC_WAIT_DATA: begin
            if (pci_done_i) begin
               next_st.ls         = plpc_pkg::PLPC_LOCKED; // RULE14
               next_st.cpl_valid  = 1'b1; // RULE9
               next_st.cpl_locked = 1'b1;
               next_st.cpl_status = plpc_pkg::CPL_STATUS_SC;
            end
         end
         plpc_pkg::PLPC_LOCKED: begin
            // lock released only at address phase of our own locked cycles
            next_st.lock_drv = !(pci_addr_phase_i && st.pci_lock_xfer); // RULE12
            if (st.unlock_seen || dn_unlock_i) begin
               next_st.ls = plpc_pkg::PLPC_DRAIN;
            end
         end
         plpc_pkg::PLPC_DRAIN: begin
            next_st.lock_drv = !(pci_addr_phase_i && st.pci_lock_xfer);
            if (!st.busy && !st.pci_start) begin
               next_st.ls            = plpc_pkg::PLPC_IDLE; // RULE16
               next_st.lock_drv      = 1'b0;
               next_st.pci_lock_xfer = 1'b0;
            end
         end
         default: begin
            next_st.ls = plpc_pkg::PLPC_IDLE;
         end
      endcase
      if (!lock_en) begin
         next_st.lock_drv = 1'b0; // RULE7
      end
      // hold intake while a transfer is running or lock is being obtained
      next_st.dn_ready = !next_st.busy && !take &&
                         (next_st.ls == plpc_pkg::PLPC_IDLE ||
                          next_st.ls == plpc_pkg::PLPC_LOCKED);
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st           <= '0;
         st.ls        <= plpc_pkg::PLPC_IDLE;
         st.intx_prev <= 4'hF;
         st.req_n     <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign intx_msg_valid_o = st.intx_valid;
   assign intx_msg_code_o  = st.intx_code;
   assign dn_ready_o       = st.dn_ready;
   assign cpl_valid_o      = st.cpl_valid;
   assign cpl_locked_o     = st.cpl_locked;
   assign cpl_status_o     = st.cpl_status;
   assign pci_start_o      = st.pci_start;
   assign pci_cmd_o        = st.pci_cmd;
   assign pci_lock_xfer_o  = st.pci_lock_xfer;
   assign req_n_o          = st.req_n;
   assign lock_n_o         = 1'b0;
   assign lock_n_oe_n_o    = !st.lock_drv; // RULE7
endmodule

//--- test/plpc_pci_model.sv
// secondary pci bus model: arbiter and target with adjustable data delay
`timescale 1ns/10ps
module plpc_pci_model (
   input  wire logic       core_clk_i, req_n_i, start_i, other_lock_i,
   input  wire logic [3:0] dly_i,
   output logic            gnt_n_o, addr_o, done_o, idle_o
);
   logic       busy;
   logic [3:0] cnt;
   assign idle_o = !busy && !other_lock_i;
   initial {gnt_n_o, addr_o, done_o, busy, cnt} = 8'h80;
   always @(posedge core_clk_i) begin
      gnt_n_o <= req_n_i;
      addr_o <= start_i;
      done_o <= 1'b0;
      if (start_i) begin
         busy <= 1'b1;
         cnt <= dly_i;
      end else if (busy && !addr_o) begin
         cnt <= cnt - 4'h1;
         busy <= cnt != 4'h0;
         done_o <= cnt == 4'h0;
      end
   end
endmodule

//--- test/plpc_top_monitor.sv
// checker for the lock conversion and pme message ports
`timescale 1ns/10ps
module plpc_top_monitor (
   input wire logic        core_clk_i, reset_i, pme_n_i, pme_msg_valid_o, dn_valid_i,
   input wire logic        dn_locked_i, dn_unlock_i, dn_ready_o, cpl_valid_o, cpl_locked_o,
   input wire logic        pci_start_o, pci_lock_xfer_o, pci_addr_phase_i, req_n_o,
   input wire logic        gnt_n_i, lock_n_i, lock_n_oe_n_o,
   input wire logic [31:0] gen_ctrl_i,
   input wire logic [15:0] pme_msg_req_id_o,
   input wire logic [7:0]  sec_bus_i, pme_msg_tag_o,
   input wire logic [2:0]  cpl_status_o,
   input wire logic [1:0]  dn_cmd_i, pci_cmd_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   logic unl, rel_d, lk_take;
   assign lk_take = dn_valid_i && dn_ready_o && !lock_n_oe_n_o;
   // an unlock is remembered until lock has been released for two cycles
   always_ff @(posedge core_clk_i) begin
      rel_d <= lock_n_oe_n_o;
      unl <= !reset_i && (dn_unlock_i || (unl && !(lock_n_oe_n_o && rel_d)));
   end
   chk_pme_tag: assert property
      (pme_msg_valid_o |-> pme_msg_tag_o == 8'h00) else $error("bad pme tag");
   chk_pme_id: assert property
      (pme_msg_valid_o |-> pme_msg_req_id_o == {sec_bus_i, 8'h00}) else $error("bad pme id");
   chk_pme_fall: assert property
      ($fell(pme_n_i) |-> ##2 pme_msg_valid_o) else $error("no pme message");
   chk_lock_gate: assert property
      (!gen_ctrl_i[12] && !$past(gen_ctrl_i[12]) |-> lock_n_oe_n_o) else $error("lock driven");
   chk_lock_req: assert property
      (dn_valid_i && dn_ready_o && dn_cmd_i == 2'h1 && dn_locked_i && gen_ctrl_i[12]
       && lock_n_oe_n_o |=> !req_n_o) else $error("no bus request");
   chk_lock_take: assert property
      ($fell(lock_n_oe_n_o) |-> $past(pci_addr_phase_i) || $past(pci_addr_phase_i, 2))
      else $error("lock not after address");
   chk_lock_hold: assert property
      ($rose(lock_n_oe_n_o) |-> $past(pci_addr_phase_i) || unl) else $error("lock dropped");
   chk_backoff: assert property
      (!gnt_n_i && !lock_n_i && lock_n_oe_n_o && !req_n_o |=> req_n_o) else $error("no backoff");
   chk_ur_cpl: assert property
      (lk_take && dn_cmd_i == 2'h1 && !dn_locked_i |=> cpl_valid_o && cpl_status_o == 3'h1)
      else $error("no unsupported completion");
   chk_lk_write: assert property
      (lk_take && dn_cmd_i == 2'h2 |=> pci_start_o && pci_lock_xfer_o && pci_cmd_o == 2'h2)
      else $error("write not locked");
   cov_backoff: cover property (!gnt_n_i && !lock_n_i && !req_n_o);
   cov_locked: cover property (cpl_valid_o && cpl_locked_o);
   cov_ur: cover property (cpl_valid_o && cpl_status_o == 3'h1);
endmodule
bind plpc_top plpc_top_monitor plpc_top_monitor_inst (.core_clk_i, .reset_i, .pme_n_i,
   .pme_msg_valid_o, .dn_valid_i, .dn_locked_i, .dn_unlock_i, .dn_ready_o, .cpl_valid_o,
   .cpl_locked_o, .pci_start_o, .pci_lock_xfer_o, .pci_addr_phase_i, .req_n_o, .gnt_n_i,
   .lock_n_i, .lock_n_oe_n_o, .gen_ctrl_i, .pme_msg_req_id_o, .sec_bus_i, .pme_msg_tag_o,
   .cpl_status_o, .dn_cmd_i, .pci_cmd_o);

//--- test/test_plpc_top.sv
// self-checking bench for the lock conversion and pme message top
`timescale 1ns/10ps
module test_plpc_top;
   logic        core_clk_i, reset_i, pme_n_i, pme_msg_ready_i, pme_msg_valid_o;
   logic        intx_msg_ready_i, intx_msg_valid_o, dn_valid_i, dn_locked_i, dn_unlock_i;
   logic        dn_ready_o, cpl_valid_o, cpl_locked_o, pci_start_o, pci_lock_xfer_o, lock_n_o;
   logic        pci_addr_phase_i, pci_done_i, pci_bus_idle_i, req_n_o, gnt_n_i, lock_n_i;
   logic        lock_n_oe_n_o, other_lk;
   logic [31:0] gen_ctrl_i, rnd;
   logic [15:0] pme_msg_req_id_o;
   logic [7:0]  sec_bus_i, pme_msg_tag_o, pme_msg_code_o, intx_msg_code_o;
   logic [3:0]  intx_n_i, dly;
   logic [2:0]  cpl_status_o;
   logic [1:0]  dn_cmd_i, pci_cmd_o;
   int          n_errors, checked, k;
   plpc_top plpc_top_inst (.core_clk_i, .reset_i, .gen_ctrl_i, .sec_bus_i, .pme_n_i,
      .pme_msg_ready_i, .pme_msg_valid_o, .pme_msg_req_id_o, .pme_msg_tag_o, .pme_msg_code_o,
      .intx_n_i, .intx_msg_ready_i, .intx_msg_valid_o, .intx_msg_code_o, .dn_valid_i,
      .dn_cmd_i, .dn_locked_i, .dn_unlock_i, .dn_ready_o, .cpl_valid_o, .cpl_locked_o,
      .cpl_status_o, .pci_start_o, .pci_cmd_o, .pci_lock_xfer_o, .pci_addr_phase_i,
      .pci_done_i, .pci_bus_idle_i, .req_n_o, .gnt_n_i, .lock_n_i, .lock_n_o, .lock_n_oe_n_o);
   plpc_pci_model plpc_pci_model_inst (.core_clk_i, .req_n_i(req_n_o), .start_i(pci_start_o),
      .other_lock_i(other_lk), .dly_i(dly), .gnt_n_o(gnt_n_i), .addr_o(pci_addr_phase_i),
      .done_o(pci_done_i), .idle_o(pci_bus_idle_i));
   // lock is a pulled-up wire that either master may pull low
   assign lock_n_i = !(other_lk || (!lock_n_oe_n_o && !lock_n_o));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] exp_intx(input int i, input logic a);
      return {8'h00, (a ? 8'h20 : 8'h24) | 8'(i)};
   endfunction
   function automatic logic sig(input int w);
      logic [6:0] v;
      v = {lock_n_oe_n_o, pci_start_o, dn_ready_o, !req_n_o, cpl_valid_o, intx_msg_valid_o,
           pme_msg_valid_o};
      return v[w];
   endfunction
   task automatic step();
      @(posedge core_clk_i);
      #1;
   endtask
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: expected %0h, got %0h", $time, exp, got);
      end
   endtask
   // bounded wait; k keeps the cycle count for callers
   task automatic wt(input int w, input int lim);
      for (k = 0; sig(w) !== 1'b1 && k < lim; k++) step();
      chk(16'h0001, 16'(sig(w)));
   endtask
   task automatic send(input logic [1:0] c, input logic lk);
      wt(4, 300);
      {dn_cmd_i, dn_locked_i, dn_valid_i} = {c, lk, 1'b1};
      step();
      dn_valid_i = 1'b0;
   endtask
   task automatic ack(input logic p);
      {pme_msg_ready_i, intx_msg_ready_i} = {p, !p};
      step();
      {pme_msg_ready_i, intx_msg_ready_i} = 2'h0;
   endtask
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = !core_clk_i;
   end
   initial begin
      repeat (70000) @(posedge core_clk_i);
      n_errors++;
      complete_run();
   end
   initial begin
      {reset_i, pme_n_i, intx_n_i, pme_msg_ready_i, intx_msg_ready_i} = 8'hFC;
      {dn_valid_i, dn_locked_i, dn_unlock_i, other_lk, dn_cmd_i, dly} = 10'h000;
      {gen_ctrl_i, sec_bus_i, n_errors, checked} = '0;
      rnd = 32'hE7FE54DB;
      repeat (20) step();
      reset_i = 1'b0;
      chk(16'h0001, 16'(req_n_o && lock_n_oe_n_o && !lock_n_o));
      send(2'h1, 1'b1);
      repeat (6) step();
      chk(16'h0001, 16'(lock_n_oe_n_o));
      repeat (2) begin
         rnd = lfsr(rnd);
         {gen_ctrl_i, dly, other_lk} = {rnd | 32'h00001000, rnd[11:8], 1'b1};
         send(2'h1, 1'b1);
         wt(3, 8);
         repeat (2) step();
         chk(16'h0001, 16'(req_n_o));
         repeat (5) step();
         chk(16'h0001, 16'(req_n_o));
         other_lk = 1'b0;
         wt(2, 80);
         chk(16'h0100, {7'h00, cpl_locked_o, 5'h00, cpl_status_o});
         chk(16'h0000, 16'(lock_n_oe_n_o));
         repeat (rnd[1:0] + 1) begin
            send(2'h2, 1'b0);
            wt(5, 3);
            chk(16'h0001, 16'(pci_lock_xfer_o));
         end
         send(2'h1, 1'b0);
         chk(16'h0011, {11'h000, cpl_valid_o, 1'b0, cpl_status_o});
         dly = 4'hB;
         send(2'h2, 1'b0);
         dn_unlock_i = 1'b1;
         step();
         dn_unlock_i = 1'b0;
         repeat (4) step();
         chk(16'h0000, 16'(lock_n_oe_n_o));
         wt(6, 40);
      end
      sec_bus_i = rnd[23:16];
      pme_n_i = 1'b0;
      wt(0, 4);
      chk({sec_bus_i, 8'h00}, pme_msg_req_id_o);
      chk(16'h0018, {pme_msg_tag_o, pme_msg_code_o});
      repeat (3) step();
      chk(16'h0001, 16'(pme_msg_valid_o));
      ack(1'b1);
      wt(0, 60000);
      chk(16'h0001, 16'(k > 1000 && k <= plpc_pkg::PME_RESEND_CYC + 4));
      ack(1'b1);
      pme_n_i = 1'b1;
      repeat (2000) step();
      chk(16'h0000, 16'(pme_msg_valid_o));
      for (int i = 0; i < 4; i++) begin
         for (int a = 0; a < 2; a++) begin
            intx_n_i[i] = a[0];
            wt(1, 6);
            chk(exp_intx(i, !a[0]), 16'(intx_msg_code_o));
            ack(1'b0);
         end
      end
      complete_run();
   end
endmodule
